// >>> apc_pkg.sv
// Constants for the auxiliary port with chip-select decoding
package apc_pkg;
    // ----------------------------------------
    // Register offsets on the special function register bus
    // ----------------------------------------
    localparam logic [7:0] APC_OFS_DATA     = 8'hE8;
    localparam logic [7:0] APC_OFS_CTRL_A   = 8'h9A;
    localparam logic [7:0] APC_OFS_CTRL_B   = 8'h9B;
    localparam logic [7:0] APC_OFS_POLARITY = 8'hAE;
    localparam logic [7:0] APC_OFS_BASE0    = 8'hC4;
    // ----------------------------------------
    // Field layout
    // ----------------------------------------
    localparam int         APC_PIN_FIELD_W  = 4;
    localparam int         APC_MASK_LSB     = 0;
    localparam int         APC_MODE_LSB     = 2;
    localparam int         APC_PINS_PER_REG = 2;
    localparam int         APC_INV_LSB      = 4;
    localparam int         APC_NUM_PINS     = 4;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] APC_CTRL_RST     = 8'h00;
    localparam logic [7:0] APC_BASE_RST     = 8'h00;
    localparam logic [3:0] APC_LATCH_RST    = 4'hF;
    localparam logic [7:0] APC_RDATA_RST    = 8'h00;
    // ----------------------------------------
    // Pin modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        APC_MODE_GPIO,
        APC_MODE_RD,
        APC_MODE_WR,
        APC_MODE_RW
    } apc_mode_t;
endpackage

// >>> apc_strobe_dec.sv
// Per-pin address comparator and strobe former
`timescale 1ns/1ps
module apc_strobe_dec
    import apc_pkg::*;
(
    // Configuration
    input  wire logic [1:0]  mode,
    input  wire logic [1:0]  mask,
    input  wire logic [15:0] base,
    input  wire logic        inv,
    // External access
    input  wire logic [15:0] xaddr,
    input  wire logic        xrd_n,
    input  wire logic        xwr_n,
    // Result
    output logic             hit,
    output logic             active,
    output logic             strobe
);
    logic [15:0] care;

    // ----------------------------------------
    // Address compare with low lines masked
    // ----------------------------------------
    assign care = 16'hFFFF << mask;
    assign hit  = ((xaddr ^ base) & care) == 16'h0000;

    // ----------------------------------------
    // Strobe select, combinational
    // ----------------------------------------
    always_comb begin
        case (apc_mode_t'(mode))
            APC_MODE_RD: active = hit & ~xrd_n;
            APC_MODE_WR: active = hit & ~xwr_n;
            APC_MODE_RW: active = hit & (~xrd_n | ~xwr_n);
            default:     active = 1'b0;
        endcase
    end

    assign strobe = inv ? active : ~active;
endmodule

// >>> apc_aux_port.sv
// Auxiliary four-pin port with per-pin chip-select decoding
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
module apc_aux_port
    import apc_pkg::*;
#(
    parameter int NUM_PINS = APC_NUM_PINS
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // Special function register bus
    input  wire logic [7:0]          sfr_addr,
    input  wire logic                sfr_wr,
    input  wire logic                sfr_rd,
    input  wire logic [7:0]          sfr_wdata,
    output logic      [7:0]          sfr_rdata,
    // External data access
    input  wire logic [15:0]         xaddr,
    input  wire logic                xrd_n,
    input  wire logic                xwr_n,
    // Port pins
    input  wire logic [NUM_PINS-1:0] aux_port_in,
    output logic      [NUM_PINS-1:0] aux_port_out,
    output logic      [NUM_PINS-1:0] aux_port_oe,
    // Interrupt inputs toward the core, active low
    output logic                     ext_irq_two_n,
    output logic                     ext_irq_three_n
);
    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (NUM_PINS != APC_NUM_PINS) begin : g_bad_pins
        $error("apc_aux_port supports exactly four pins");
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]          pin_mode_ctrl_a_r;
    logic [7:0]          pin_mode_ctrl_b_r;
    logic [7:0]          strobe_polarity_ctrl_r;
    logic [7:0]          base_hi_r [NUM_PINS];
    logic [7:0]          base_lo_r [NUM_PINS];
    logic [NUM_PINS-1:0] latch_r;
    logic [7:0]          rdata_nxt;
    logic [1:0]          pin_mode [NUM_PINS];
    logic [1:0]          pin_mask [NUM_PINS];
    logic [NUM_PINS-1:0] pin_inv;
    logic [NUM_PINS-1:0] pin_gpio;
    logic [NUM_PINS-1:0] pin_hit;
    logic [NUM_PINS-1:0] pin_active;
    logic [NUM_PINS-1:0] pin_strobe;

    function automatic logic [7:0] field_of(input logic [7:0] a, input logic [7:0] b, input int p);
        logic [7:0] r;
        r = (p < APC_PINS_PER_REG) ? a : b;
        field_of = r >> ((p % APC_PINS_PER_REG) * APC_PIN_FIELD_W);
    endfunction

    // ----------------------------------------
    // Control register writes
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_mode_ctrl_a_r      <= APC_CTRL_RST;
            pin_mode_ctrl_b_r      <= APC_CTRL_RST;
            strobe_polarity_ctrl_r <= APC_CTRL_RST;
        end else if (sfr_wr) begin
            if (sfr_addr == APC_OFS_CTRL_A) begin
                pin_mode_ctrl_a_r <= sfr_wdata;
            end else if (sfr_addr == APC_OFS_CTRL_B) begin
                pin_mode_ctrl_b_r <= sfr_wdata;
            end else if (sfr_addr == APC_OFS_POLARITY) begin
                strobe_polarity_ctrl_r <= sfr_wdata;
            end
        end
    end

    // ----------------------------------------
    // Per-pin logic
    // ----------------------------------------
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        logic [7:0] fld;
        assign fld         = field_of(pin_mode_ctrl_a_r, pin_mode_ctrl_b_r, p);
        assign pin_mode[p] = fld[APC_MODE_LSB +: 2];
        assign pin_mask[p] = fld[APC_MASK_LSB +: 2];
        assign pin_inv[p]  = strobe_polarity_ctrl_r[APC_INV_LSB + p];
        assign pin_gpio[p] = pin_mode[p] == 2'(APC_MODE_GPIO);

        // Base address bytes
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                base_hi_r[p] <= APC_BASE_RST;
                base_lo_r[p] <= APC_BASE_RST;
            end else if (sfr_wr && sfr_addr == APC_OFS_BASE0 + 8'(2 * p)) begin
                base_hi_r[p] <= sfr_wdata;
            end else if (sfr_wr && sfr_addr == APC_OFS_BASE0 + 8'(2 * p + 1)) begin
                base_lo_r[p] <= sfr_wdata;
            end
        end

        // Data latch, written only while the pin is plain I/O
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                latch_r[p] <= APC_LATCH_RST[p];
            end else if (sfr_wr && sfr_addr == APC_OFS_DATA && pin_gpio[p]) begin
                latch_r[p] <= sfr_wdata[p];
            end
        end

        apc_strobe_dec u_dec (
            .mode   (pin_mode[p]),
            .mask   (pin_mask[p]),
            .base   ({base_hi_r[p], base_lo_r[p]}),
            .inv    (pin_inv[p]),
            .xaddr  (xaddr),
            .xrd_n  (xrd_n),
            .xwr_n  (xwr_n),
            .hit    (pin_hit[p]),
            .active (pin_active[p]),
            .strobe (pin_strobe[p])
        );

        // Quasi-bidirectional I/O pulls low only; strobes drive both ways
        assign aux_port_out[p] = pin_gpio[p] ? 1'b0 : pin_strobe[p];
        assign aux_port_oe[p]  = pin_gpio[p] ? ~latch_r[p] : 1'b1;

        gpio_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            pin_gpio[p] |-> (aux_port_oe[p] == ~latch_r[p]) && !aux_port_out[p])
            else $error("plain I/O pin drive wrong");
        rd_strobe_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            pin_mode[p] == 2'(APC_MODE_RD) |-> aux_port_out[p] == (pin_inv[p] ~^ (pin_hit[p] && !xrd_n)))
            else $error("read strobe wrong");
        wr_strobe_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            pin_mode[p] == 2'(APC_MODE_WR) |-> pin_active[p] == (pin_hit[p] && !xwr_n))
            else $error("write strobe wrong");
        rw_strobe_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            pin_mode[p] == 2'(APC_MODE_RW) && pin_hit[p] && (!xrd_n || !xwr_n) |-> pin_active[p])
            else $error("read-write strobe missing");
        base_match_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            pin_hit[p] |-> xaddr[15:8] == base_hi_r[p])
            else $error("hit outside high base byte");
        mask_block_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            pin_mask[p] == 2'd2 && xaddr[15:2] == {base_hi_r[p], base_lo_r[p][7:2]} |-> pin_hit[p])
            else $error("masked block not matched");
        strobe_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            !pin_gpio[p] && xrd_n && xwr_n |-> aux_port_oe[p] && aux_port_out[p] == !pin_inv[p])
            else $error("idle strobe polarity wrong");
        latch_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            sfr_wr && sfr_addr == APC_OFS_DATA && !pin_gpio[p] |=> $stable(latch_r[p]))
            else $error("strobe pin latch changed");
    end

    // ----------------------------------------
    // Interrupt inputs from pins 3 and 2 in mode 0
    // ----------------------------------------
    assign ext_irq_two_n   = pin_gpio[3] ? aux_port_in[3] : 1'b1;
    assign ext_irq_three_n = pin_gpio[2] ? aux_port_in[2] : 1'b1;

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    always_comb begin
        rdata_nxt = APC_RDATA_RST;
        if (sfr_addr == APC_OFS_DATA) begin
            rdata_nxt = {4'h0, aux_port_in};
        end else if (sfr_addr == APC_OFS_CTRL_A) begin
            rdata_nxt = pin_mode_ctrl_a_r;
        end else if (sfr_addr == APC_OFS_CTRL_B) begin
            rdata_nxt = pin_mode_ctrl_b_r;
        end else if (sfr_addr == APC_OFS_POLARITY) begin
            rdata_nxt = strobe_polarity_ctrl_r;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (sfr_addr == APC_OFS_BASE0 + 8'(2 * i)) begin
                    rdata_nxt = base_hi_r[i];
                end else if (sfr_addr == APC_OFS_BASE0 + 8'(2 * i + 1)) begin
                    rdata_nxt = base_lo_r[i];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= APC_RDATA_RST;
        end else if (sfr_rd) begin
            sfr_rdata <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // Checks on registers and interrupts
    // ----------------------------------------
    ctrl_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        sfr_wr && sfr_addr == APC_OFS_CTRL_A |=> pin_mode_ctrl_a_r == $past(sfr_wdata))
        else $error("control write lost");
    data_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        sfr_rd && sfr_addr == APC_OFS_DATA |=> sfr_rdata[7:4] == 4'h0 && sfr_rdata[3:0] == $past(aux_port_in))
        else $error("data read wrong");
    irq_feed_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        pin_gpio[3] |-> ext_irq_two_n == aux_port_in[3])
        else $error("interrupt two not fed");
    irq_three_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        pin_gpio[2] |-> ext_irq_three_n == aux_port_in[2])
        else $error("interrupt three not fed");
endmodule

// >>> apc_periph_model.sv
// Peripheral side of the port: pull-up resolution and a select counter
`timescale 1ns/1ps
module apc_periph_model (
    // Pin drive from the port
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    // Resolved pin levels and selects seen on pin 0
    output logic      [3:0] pin_lvl,
    output int              sel_cnt
);
    // Released pins float high through the pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_lvl[i] = pin_oe[i] ? pin_out[i] : 1'b1;
        end
    end
    // Count active-high select pulses on pin 0
    initial sel_cnt = 0;
    always @(posedge pin_out[0]) begin
        if (pin_oe[0] === 1'b1) sel_cnt++;
    end
endmodule

// >>> tb.sv
// Self-checking testbench for the auxiliary port
`timescale 1ns/1ps
module tb;
    import apc_pkg::*;
    logic        core_clk  = 1'b0;
    logic        rst_n     = 1'b0;
    logic [7:0]  sfr_addr  = 8'h00;
    logic        sfr_wr    = 1'b0;
    logic        sfr_rd    = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  sfr_rdata;
    logic [15:0] xaddr     = 16'h0000;
    logic        xrd_n     = 1'b1;
    logic        xwr_n     = 1'b1;
    logic [3:0]  lvl, pout, poe;
    logic        irq2_n, irq3_n;
    logic [7:0]  rd;
    int          sel_cnt, c0;
    int          num_errors = 0;
    int          n_tests    = 0;
    always #4 core_clk = ~core_clk;
    apc_aux_port #(.NUM_PINS(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .xaddr(xaddr), .xrd_n(xrd_n), .xwr_n(xwr_n), .aux_port_in(lvl), .aux_port_out(pout),
        .aux_port_oe(poe), .ext_irq_two_n(irq2_n), .ext_irq_three_n(irq3_n));
    apc_periph_model per_u (.pin_out(pout), .pin_oe(poe), .pin_lvl(lvl), .sel_cnt(sel_cnt));
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task chk(string name, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task sfr_write(logic [7:0] a, logic [7:0] d);
        @(posedge core_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge core_clk);
        sfr_wr    <= 1'b0;
    endtask
    task sfr_read(logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge core_clk);
        sfr_rd   <= 1'b0;
        #1 d = sfr_rdata;
    endtask
    task xacc(logic [15:0] a, logic r, logic w);
        @(posedge core_clk);
        xaddr <= a;
        xrd_n <= r;
        xwr_n <= w;
        #1;
    endtask
    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset();
        chk("oe", {4'h0, poe}, 8'h00);
        sfr_read(APC_OFS_DATA, rd);
        chk("data", rd, 8'h0F);
        sfr_read(8'h00, rd);
        chk("unmapped", rd, 8'h00);
        chk("irq", {6'h0, irq2_n, irq3_n}, 8'h03);
        $display("test reset done");
    endtask
    task t_example();
        sfr_write(APC_OFS_BASE0, 8'h12);
        sfr_write(APC_OFS_BASE0 + 8'h01, 8'h34);
        sfr_write(APC_OFS_CTRL_A, 8'h0A);
        sfr_write(APC_OFS_CTRL_B, 8'h00);
        sfr_write(APC_OFS_POLARITY, 8'h10);
        sfr_read(APC_OFS_BASE0 + 8'h01, rd);
        chk("base lo", rd, 8'h34);
        sfr_read(APC_OFS_CTRL_A, rd);
        chk("ctrl a", rd, 8'h0A);
        c0 = sel_cnt;
        for (int a = 16'h1233; a <= 16'h1238; a++) begin
            xacc(16'(a), 1'b1, 1'b0);
            chk("p0 wr", {7'h0, pout[0]}, {7'h0, a >= 16'h1234 && a <= 16'h1237});
            xacc(16'(a), 1'b1, 1'b1);
            chk("p0 idle", {7'h0, pout[0]}, 8'h00);
        end
        xacc(16'h1234, 1'b0, 1'b1);
        chk("p0 rd", {7'h0, pout[0]}, 8'h00);
        chk("sel cnt", 8'(sel_cnt - c0), 8'h04);
        chk("p0 oe", {7'h0, poe[0]}, 8'h01);
        xacc(16'h1234, 1'b1, 1'b1);
        $display("test example done");
    endtask
    task t_modes();
        logic [1:0] m;
        sfr_write(APC_OFS_BASE0 + 8'h02, 8'h40);
        sfr_write(APC_OFS_BASE0 + 8'h03, 8'h00);
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            sfr_write(APC_OFS_CTRL_A, {m, 6'h0A});
            xacc(16'h4000, 1'b0, 1'b1);
            chk("p1 rd", {6'h0, poe[1], lvl[1]}, {6'h0, m != 2'd0, !(m == 2'd1 || m == 2'd3)});
            xacc(16'h4000, 1'b1, 1'b0);
            chk("p1 wr", {6'h0, poe[1], lvl[1]}, {6'h0, m != 2'd0, !(m >= 2'd2)});
            xacc(16'h4001, 1'b0, 1'b0);
            chk("p1 miss", {7'h0, lvl[1]}, 8'h01);
            xacc(16'h4000, 1'b1, 1'b1);
        end
        sfr_write(APC_OFS_CTRL_A, 8'h5A);
        xacc(16'h4001, 1'b0, 1'b1);
        chk("p1 mask", {7'h0, lvl[1]}, 8'h00);
        xacc(16'h4002, 1'b0, 1'b1);
        chk("p1 edge", {7'h0, lvl[1]}, 8'h01);
        xacc(16'h4000, 1'b1, 1'b1);
        $display("test modes done");
    endtask
    task t_data();
        sfr_write(APC_OFS_DATA, 8'hF9);
        sfr_read(APC_OFS_DATA, rd);
        chk("data", rd, 8'h0A);
        chk("oe", {4'h0, poe}, 8'h07);
        chk("irq", {6'h0, irq2_n, irq3_n}, 8'h02);
        sfr_write(APC_OFS_DATA, 8'hF7);
        #1 chk("irq", {6'h0, irq2_n, irq3_n}, 8'h01);
        $display("test data done");
    endtask
    task t_reset_again();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        #1 chk("oe rst", {4'h0, poe}, 8'h00);
        sfr_read(APC_OFS_CTRL_A, rd);
        chk("ctrl rst", rd, 8'h00);
        sfr_read(APC_OFS_DATA, rd);
        chk("data rst", rd, 8'h0F);
        $display("test reset again done");
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_example();
        t_modes();
        t_data();
        t_reset_again();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        $display("ERROR run limit expected done seen hang");
        num_errors++;
        tally_and_finish();
    end
endmodule
